// ===== hw/fault_temp_pkg.sv
// Package with offsets, field positions and reset values of the status bank
`default_nettype none
package fault_temp_pkg;
    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam logic [7:0] RAIL_FAULT_STATUS_TWO_OFS   = 8'hb3;
    localparam logic [7:0] THERMAL_CRITICAL_STATUS_OFS = 8'hb4;
    localparam logic [7:0] THERMAL_HOT_STATUS_OFS      = 8'hb5;
    localparam int unsigned FLAG_COUNT = 5;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [2:0] RESERVED_BITS = 3'h0;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ********************************************************************
    // Rail fault bit positions
    // ********************************************************************
    localparam int unsigned AUX_LDO1_FAULT_BIT        = 4;
    localparam int unsigned TERMINATION_LDO_FAULT_BIT = 3;
    localparam int unsigned SWITCH_B2_FAULT_BIT       = 2;
    localparam int unsigned SWITCH_B1_FAULT_BIT       = 1;
    localparam int unsigned AUX_LDO3_FAULT_BIT        = 0;

    // ********************************************************************
    // Temperature sensor bit positions, shared by both thermal registers
    // ********************************************************************
    localparam int unsigned DIE_REST_SENSOR_BIT        = 4;
    localparam int unsigned TERMINATION_LDO_SENSOR_BIT = 3;
    localparam int unsigned UPPER_RIGHT_SENSOR_BIT     = 2;
    localparam int unsigned UPPER_LEFT_SENSOR_BIT      = 1;
    localparam int unsigned LOWER_RIGHT_SENSOR_BIT     = 0;

    // ********************************************************************
    // Synchroniser word layout: rail, critical, hot groups
    // ********************************************************************
    localparam int unsigned SYNC_WIDTH    = 15;
    localparam int unsigned RAIL_SYNC_LSB = 10;
    localparam int unsigned CRIT_SYNC_LSB = 5;
    localparam int unsigned HOT_SYNC_LSB  = 0;
endpackage : fault_temp_pkg
`default_nettype wire

// ===== hw/fault_temp_status_regs.sv
// Sticky rail-fault and temperature status registers, write-one-to-clear
//
// Function
// - Five rail loss-of-regulation events set sticky bits 4..0 of b3h.
// - A set rail fault bit holds until host writes 1 there.
// - Rail fault register sits at b3h, resets to zero.
// - Five sensors each set their own critical flag above threshold.
// - Critical register sits at b4h, resets to zero.
// - Each sensor sets its own hot flag, kept apart from critical.
// - Hot register sits at b5h, resets to zero.
// - Thermal flags hold until host writes 1 to clear them.
// - Sensor bits: die 4, termination 3, upper right 2, left 1, lower 0.
//
// Notes
// Event inputs are levels from analog comparators, so each passes two
// flops before it may touch a flag; a flag sets three edges after its
// input rises, and a level that stays high keeps setting it again.
// Read data is registered from the address of the previous cycle, so a
// host sees a cleared flag one edge after its clearing write lands.
// Set wins over clear: a fault arriving while the host clears it must
// survive, at the cost of a host that clears a stuck level in vain.
// Low clock enable freezes synchronisers, flags and read data alike,
// and a write offered then is dropped without notice.
// Reserved bits 7..5 read zero in every register and take no write.
// Offsets outside the three registers read zero.
// No interrupt is raised here; the host polls these registers.
`default_nettype none
module fault_temp_status_regs
    import fault_temp_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        clk_en,
    // Register port from the serial interface logic, same clock
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Rail loss-of-regulation events, asynchronous analog comparators
    input  wire logic        aux_ldo1_rail_lost,
    input  wire logic        termination_ldo_rail_lost,
    input  wire logic        switch_b2_rail_lost,
    input  wire logic        switch_b1_rail_lost,
    input  wire logic        aux_ldo3_rail_lost,
    // Per-sensor threshold comparators, bit order as the registers
    input  wire logic [4:0]  sensor_over_critical,
    input  wire logic [4:0]  sensor_over_hot
);

    // ********************************************************************
    // Event gathering into register bit order
    // ********************************************************************
    // Comparator outputs are gathered into register order here, before
    // synchronising, so that every later stage works on whole groups
    logic [4:0] rail_raw;
    logic [4:0] crit_raw;
    logic [4:0] hot_raw;

    always_comb begin
        rail_raw = FLAGS_RESET;
        rail_raw[AUX_LDO1_FAULT_BIT]        = aux_ldo1_rail_lost;
        rail_raw[TERMINATION_LDO_FAULT_BIT] = termination_ldo_rail_lost;
        rail_raw[SWITCH_B2_FAULT_BIT]       = switch_b2_rail_lost;
        rail_raw[SWITCH_B1_FAULT_BIT]       = switch_b1_rail_lost;
        rail_raw[AUX_LDO3_FAULT_BIT]        = aux_ldo3_rail_lost;
    end

    // Same order for critical and hot; both sets kept apart
    // sensor to bit map
    always_comb begin
        crit_raw = FLAGS_RESET;
        hot_raw  = FLAGS_RESET;
        crit_raw[DIE_REST_SENSOR_BIT] =
            sensor_over_critical[DIE_REST_SENSOR_BIT];
        crit_raw[TERMINATION_LDO_SENSOR_BIT] =
            sensor_over_critical[TERMINATION_LDO_SENSOR_BIT];
        crit_raw[UPPER_RIGHT_SENSOR_BIT] =
            sensor_over_critical[UPPER_RIGHT_SENSOR_BIT];
        crit_raw[UPPER_LEFT_SENSOR_BIT] =
            sensor_over_critical[UPPER_LEFT_SENSOR_BIT];
        crit_raw[LOWER_RIGHT_SENSOR_BIT] =
            sensor_over_critical[LOWER_RIGHT_SENSOR_BIT];
        hot_raw[DIE_REST_SENSOR_BIT] =
            sensor_over_hot[DIE_REST_SENSOR_BIT];
        hot_raw[TERMINATION_LDO_SENSOR_BIT] =
            sensor_over_hot[TERMINATION_LDO_SENSOR_BIT];
        hot_raw[UPPER_RIGHT_SENSOR_BIT] =
            sensor_over_hot[UPPER_RIGHT_SENSOR_BIT];
        hot_raw[UPPER_LEFT_SENSOR_BIT] =
            sensor_over_hot[UPPER_LEFT_SENSOR_BIT];
        hot_raw[LOWER_RIGHT_SENSOR_BIT] =
            sensor_over_hot[LOWER_RIGHT_SENSOR_BIT];
    end

    // ********************************************************************
    // Two-stage synchronisers; first stage feeds only the second
    // ********************************************************************
    // Word layout: rail events on top, then critical, then hot; one
    // vector keeps every synchroniser stage under one enable
    logic [SYNC_WIDTH-1:0] meta_q;
    logic [SYNC_WIDTH-1:0] meta_d;
    logic [SYNC_WIDTH-1:0] sync_q;
    logic [SYNC_WIDTH-1:0] sync_d;

    // Next values of both stages
    // Enable low holds both stages, so no edge is lost or invented
    always_comb begin
        meta_d = clk_en ? {rail_raw, crit_raw, hot_raw} : meta_q;
        sync_d = clk_en ? meta_q : sync_q;
    end

    // Synchroniser registers
    // Reset, not enable, clears them, so stale events do not survive reset
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta_q <= {3{FLAGS_RESET}};
            sync_q <= {3{FLAGS_RESET}};
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    // ********************************************************************
    // Sticky flags
    // ********************************************************************
    // Flags are plain flops; the read mux looks only at them, never at
    // the raw events, so a read cannot catch a half-synchronised level
    logic [4:0] rail_flags_q;
    logic [4:0] rail_flags_d;
    logic [4:0] crit_flags_q;
    logic [4:0] crit_flags_d;
    logic [4:0] hot_flags_q;
    logic [4:0] hot_flags_d;
    logic [7:0] reg_rdata_d;

    // ********************************************************************
    // Helper functions
    // ********************************************************************
    // Write strobe aimed at one offset; the three flag groups share it
    function automatic logic wr_hit(
        input logic       wr,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        wr_hit = wr && (addr == ofs);
    endfunction : wr_hit

    // Write-one-to-clear with set priority; a level holds the flag set
    // Upper write bits never reach the clear mask
    function automatic logic [4:0] sticky_next(
        input logic [4:0] flags,
        input logic [4:0] events,
        input logic       hit,
        input logic [4:0] wdata
    );
        logic [4:0] clear;
        clear = hit ? wdata : FLAGS_RESET;
        sticky_next = (flags & ~clear) | events;
    endfunction : sticky_next

    // Next flag values and read mux
    always_comb begin
        rail_flags_d = rail_flags_q;
        crit_flags_d = crit_flags_q;
        hot_flags_d  = hot_flags_q;
        reg_rdata_d  = reg_rdata;
        if (clk_en) begin
            // rail flags held until written one
            rail_flags_d = sticky_next(rail_flags_q,
                sync_q[RAIL_SYNC_LSB +: FLAG_COUNT],
                wr_hit(reg_wr, reg_addr, RAIL_FAULT_STATUS_TWO_OFS),
                reg_wdata[FLAG_COUNT-1:0]);
            crit_flags_d = sticky_next(crit_flags_q,
                sync_q[CRIT_SYNC_LSB +: FLAG_COUNT],
                wr_hit(reg_wr, reg_addr, THERMAL_CRITICAL_STATUS_OFS),
                reg_wdata[FLAG_COUNT-1:0]);
            hot_flags_d = sticky_next(hot_flags_q,
                sync_q[HOT_SYNC_LSB +: FLAG_COUNT],
                wr_hit(reg_wr, reg_addr, THERMAL_HOT_STATUS_OFS),
                reg_wdata[FLAG_COUNT-1:0]);
            // Unmapped offsets read zero; a write there changes nothing
            // reserved bits read zero
            unique case (reg_addr)
                RAIL_FAULT_STATUS_TWO_OFS:
                    reg_rdata_d = {RESERVED_BITS, rail_flags_q};
                THERMAL_CRITICAL_STATUS_OFS:
                    reg_rdata_d = {RESERVED_BITS, crit_flags_q};
                THERMAL_HOT_STATUS_OFS:
                    reg_rdata_d = {RESERVED_BITS, hot_flags_q};
                default:
                    reg_rdata_d = READ_NONE;
            endcase
        end
    end

    // Read data resets with the flags, so the first read after reset
    // shows zero whatever offset the host asks for
    // all flags reset to zero
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rail_flags_q <= FLAGS_RESET;
            crit_flags_q <= FLAGS_RESET;
            hot_flags_q  <= FLAGS_RESET;
            reg_rdata    <= READ_NONE;
        end else begin
            rail_flags_q <= rail_flags_d;
            crit_flags_q <= crit_flags_d;
            hot_flags_q  <= hot_flags_d;
            reg_rdata    <= reg_rdata_d;
        end
    end

endmodule : fault_temp_status_regs
`default_nettype wire

// ===== test/fault_temp_props.sv
// Checker on the status bank ports
`default_nettype none
module fault_temp_props (
    // Clock, reset and register port
    input wire logic       mclk, resetn, clk_en, reg_wr,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    // Event inputs
    input wire logic       aux_ldo1_rail_lost, termination_ldo_rail_lost,
    input wire logic       switch_b2_rail_lost, switch_b1_rail_lost,
    input wire logic       aux_ldo3_rail_lost,
    input wire logic [4:0] sensor_over_critical, sensor_over_hot
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Plain reads, no write in the same cycle
    wire logic rd3 = clk_en && !reg_wr && reg_addr == 8'hb3;
    wire logic rd5 = clk_en && !reg_wr && reg_addr == 8'hb5;
    wire logic rails = aux_ldo1_rail_lost | termination_ldo_rail_lost |
        switch_b2_rail_lost | switch_b1_rail_lost | aux_ldo3_rail_lost;
    a_rsvd_read_zero: assert property (
        reg_rdata[7:5] == 3'h0) else $error("reserved read bits set");
    a_unmapped_read_zero: assert property (
        clk_en && (reg_addr < 8'hb3 || reg_addr > 8'hb5)
        |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rail_sets_top: assert property (
        (rd3 && aux_ldo1_rail_lost)[*4] |=> reg_rdata[4])
        else $error("rail fault bit 4 not set");
    a_crit_sets_die: assert property (
        (clk_en && !reg_wr && reg_addr == 8'hb4 &&
        sensor_over_critical[4])[*4] |=> reg_rdata[4])
        else $error("critical bit 4 not set");
    a_hot_sets_low: assert property (
        (rd5 && sensor_over_hot[0])[*4] |=> reg_rdata[0])
        else $error("hot bit 0 not set");
    a_flags_stay_set: assert property (
        rd3[*2] |=> (reg_rdata & $past(reg_rdata)) == $past(reg_rdata))
        else $error("rail flag lost without write");
    a_write_one_clears: assert property (
        (clk_en && !rails)[*3]
        ##0 (reg_wr && reg_addr == 8'hb3 && reg_wdata[4:0] == 5'h1f)
        ##1 rd3 |=> reg_rdata == 8'h00) else $error("clear failed");
    a_set_beats_clear: assert property (
        (rd5 && sensor_over_hot[0])[*3]
        ##1 (clk_en && reg_wr && reg_addr == 8'hb5 && sensor_over_hot[0])
        ##1 rd5 |=> reg_rdata[0]) else $error("event lost on clear");
endmodule : fault_temp_props
bind fault_temp_status_regs fault_temp_props u_fault_temp_props (.*);
`default_nettype wire

// ===== test/host_model.sv
// Host model driving the register port
`default_nettype none
module host_model (
    // Clock and register port
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata,
    output var logic        reg_wr,
    output var logic [7:0]  reg_addr, reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_wr, reg_addr, reg_wdata} = 17'h0;
    task automatic wr(input logic [7:0] a, d);
        @(negedge mclk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk) {reg_wr, reg_wdata} = {1'b0, ~d};
    endtask : wr
    // Read data lands one edge after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk) reg_addr = a;
        @(negedge mclk) d = reg_rdata;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ===== test/tb_fault_temp_status_regs.sv
// Self-checking bench for the status bank
`default_nettype none
module tb_fault_temp_status_regs;
    import fault_temp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(g, w) begin checks_done++; if ((g) !== (w)) begin \
        error_cnt++; $display("CHECK FAILED %0t got %h want %h", \
        $time, g, w); end end
    logic mclk = 0, resetn = 0, clk_en = 1, reg_wr;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [4:0] ev [3] = '{default: 5'h0};
    logic [4:0] expf [3] = '{default: 5'h0};
    int error_cnt = 0, checks_done = 0;
    always #25 mclk = ~mclk;
    host_model u_host_model (.mclk(mclk), .reg_rdata(reg_rdata),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    fault_temp_status_regs u_fault_temp_status_regs (.mclk(mclk),
        .resetn(resetn), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .aux_ldo1_rail_lost(ev[0][4]), .termination_ldo_rail_lost(ev[0][3]),
        .switch_b2_rail_lost(ev[0][2]), .switch_b1_rail_lost(ev[0][1]),
        .aux_ldo3_rail_lost(ev[0][0]), .sensor_over_critical(ev[1]),
        .sensor_over_hot(ev[2]));
    // Flags left after a write of w
    function automatic logic [4:0] cleared(logic [4:0] f, logic [7:0] w);
        return f & ~w[4:0];
    endfunction : cleared
    // Read one offset, unmapped beyond the third, and compare
    task automatic chk_reg(int r);
        u_host_model.rd(RAIL_FAULT_STATUS_TWO_OFS + 8'(r), d);
        `CHK(d, {3'h0, (r < 3) ? expf[r] : 5'h0})
    endtask : chk_reg
    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    // Generous bound of 20000 cycles, the sequence needs about a thousand cycles
    initial begin
        #(20000 * 50);
        error_cnt++;
        end_of_test();
    end
    initial begin
        int r;
        logic [7:0] w;
        void'($urandom(32'hf09d));
        repeat (10) @(negedge mclk);
        resetn = 1;
        for (int k = 0; k < 4; k++) chk_reg(k);
        // One event per bit, then a zero write and a one write
        for (int k = 0; k < 3; k++) for (int i = 0; i < 5; i++) begin
            ev[k][i] = 1'b1;
            repeat (5) u_host_model.rd(8'hb3 + 8'(k), d);
            ev[k][i] = 1'b0;
            expf[k][i] = 1'b1;
            repeat (2) chk_reg(k);
            u_host_model.wr(8'hb3 + 8'(k), ~(8'h1 << i));
            expf[k] = cleared(expf[k], ~(8'h1 << i));
            chk_reg(k);
            u_host_model.wr(8'hb3 + 8'(k), 8'h1 << i);
            expf[k] = cleared(expf[k], 8'h1 << i);
            chk_reg(k);
        end
        // Random event bursts and random clearing writes
        repeat (40) begin
            r = $urandom_range(2);
            w = 8'($urandom);
            ev[r] = 5'($urandom);
            repeat (5) u_host_model.rd(8'hb3 + 8'(r), d);
            expf[r] |= ev[r];
            ev[r] = 5'h0;
            chk_reg(r);
            u_host_model.wr(8'hb3 + 8'(r), w);
            expf[r] = cleared(expf[r], w);
            chk_reg(r);
        end
        // Clearing write while the event is still present
        ev[2][0] = 1'b1;
        repeat (3) u_host_model.rd(8'hb5, d);
        u_host_model.wr(8'hb5, 8'h01);
        ev[2][0] = 1'b0;
        expf[2][0] = 1'b1;
        chk_reg(2);
        // Event gone just before the clearing edge: only set priority keeps it
        ev[1][3] = 1'b1;
        repeat (3) u_host_model.rd(8'hb4, d);
        ev[1][3] = 1'b0;
        u_host_model.wr(8'hb4, 8'h08);
        expf[1][3] = 1'b1;
        chk_reg(1);
        // Frozen clock enable: no event captured, no write taken
        clk_en = 1'b0;
        ev[0] = 5'h1f;
        u_host_model.wr(8'hb5, 8'hff);
        ev[0] = 5'h0;
        clk_en = 1'b1;
        chk_reg(0);
        chk_reg(2);
        for (int k = 0; k < 3; k++) begin
            u_host_model.wr(8'hb3 + 8'(k), 8'hff);
            expf[k] = 5'h0;
            chk_reg(k);
        end
        end_of_test();
    end
endmodule : tb_fault_temp_status_regs
`default_nettype wire
